// ### core/dmi_bank_ram.sv
// banked general purpose data ram, one write port, asynchronous read
// assumes the caller registers the read data and gives one access per cycle
`timescale 1ns/10ps
module dmi_bank_ram
  import dmi_pkg::*;
#(
  parameter int W     = DW,
  parameter int DEPTH = RAM_WORDS_DEF,
  parameter int BANKS = NUM_BANKS
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic                     bank,
  input  wire logic [$clog2(DEPTH)-1:0] idx,
  input  wire logic [W-1:0]             wdata,
  output logic      [W-1:0]             rdata
);

  // contents are undefined after power up, as for any ram
  logic [W-1:0] mem [BANKS*DEPTH];

  wire logic [$clog2(DEPTH):0] slot = {bank, idx};

  assign rdata = mem[slot];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[slot] <= wdata;
    end
  end

endmodule

// ### core/dmi_core.sv
// data memory address logic: pointers, windows, bank select, banked ram
// assumes a single operand access per cycle from the execution unit;
// special registers of other blocks answer combinationally on ext_*
//
// Notes on behaviour
// RULE1: window accesses go to the address in the paired pointer, nothing stored.
// RULE2: first window pair always lands in bank 0.
// RULE3: second window pair uses the bank held in the bank select bit.
// RULE4: a window reached through a pointer reads 00h, writes do nothing.
// RULE5: both pointers are real read and write registers.
// RULE6: direct operand addresses always reach bank 0.
// RULE7: unused special locations read 00h.
// RULE8: bank select bit 0 picks bank 0 or 1, upper bits read zero.
// RULE9: resets clear the bank, except watchdog reset in sleep or idle.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module dmi_core
  import dmi_pkg::*;
#(
  parameter int RAM_WORDS = RAM_WORDS_DEF
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [7:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [7:0]   rdata,
  input  wire logic         rst_evt,
  input  wire logic         rst_keep_bank,
  output dmi_sfr_req_t      ext_req,
  input  wire logic [7:0]   ext_rdata,
  input  wire logic         ext_hit,
  output logic              bank_sel
);

  localparam int IW = $clog2(RAM_WORDS);

  function automatic logic is_window(input logic [7:0] a);
    is_window = (a == A_WIN0) || (a == A_WIN1);
  endfunction

  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (int'(a) >= int'(GP_BASE)) && (int'(a) < int'(GP_BASE) + RAM_WORDS);
  endfunction

  function automatic logic is_own(input logic [7:0] a);
    is_own = (a == A_PTR0) || (a == A_PTR1) || (a == A_BANK);
  endfunction

  // state
  logic [7:0] ptr0_q;
  logic [7:0] ptr1_q;
  logic       bank_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // address resolution
  wire logic       win0_hit = (addr == A_WIN0);
  wire logic       win1_hit = (addr == A_WIN1);
  wire logic       indirect = win0_hit || win1_hit;
  wire logic       access   = wr || rd;

  // the pointer replaces the operand address, the window holds nothing
  wire logic [7:0] eff_addr = win0_hit ? ptr0_q :  // RULE1
                              win1_hit ? ptr1_q : addr;

  // only the second pair sees the bank bit; direct and first pair stay in bank 0
  wire logic       eff_bank = win1_hit ? bank_q : 1'b0;  // RULE2 RULE3 RULE6

  // a window seen through a pointer is a null location; it has no storage,
  // so a dropped write and a zero read are the only safe answers
  wire logic       null_hit = indirect && is_window(eff_addr);  // RULE4

  // the special region is common to both banks, so no bank goes out on ext_req
  wire logic       gp_hit   = is_gp(eff_addr);
  wire logic       sfr_area = (eff_addr < GP_BASE);
  wire logic       own_hit  = is_own(eff_addr);
  wire logic       ext_sel  = sfr_area && !own_hit && !is_window(eff_addr);

  // pointer and bank writes
  wire logic       wr_live  = wr && !null_hit;
  wire logic       wr_ptr0  = wr_live && (eff_addr == A_PTR0);
  wire logic       wr_ptr1  = wr_live && (eff_addr == A_PTR1);
  wire logic       wr_bank  = wr_live && (eff_addr == A_BANK);

  // ram port
  // contents are not reset: clearing them would need a sweep of many cycles
  wire logic          ram_we   = wr_live && gp_hit;
  wire logic [IW-1:0] ram_idx  = IW'(eff_addr - GP_BASE);
  logic      [7:0]    ram_rdata;

  dmi_bank_ram #(
    .W     (DW),
    .DEPTH (RAM_WORDS),
    .BANKS (NUM_BANKS)
  ) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .bank  (eff_bank),
    .idx   (ram_idx),
    .wdata (wdata),
    .rdata (ram_rdata)
  );

  // forward everything in the special region that is not ours
  assign ext_req.addr  = eff_addr;
  assign ext_req.wdata = wdata;
  assign ext_req.wr    = wr_live && ext_sel;
  assign ext_req.rd    = rd && !null_hit && ext_sel;

  // bank select register image, unused bits forced low
  wire logic [7:0] bank_img = {7'h00, bank_q};  // RULE8

  // read selection; anything unclaimed answers zero
  wire logic [7:0] ext_val = ext_hit ? ext_rdata : ZERO_B;  // RULE7

  always_comb begin
    rdata_d = ZERO_B;
    if (null_hit) begin
      rdata_d = ZERO_B;  // RULE4
    end else if (gp_hit) begin
      rdata_d = ram_rdata;
    end else if (eff_addr == A_PTR0) begin
      rdata_d = ptr0_q;  // RULE5
    end else if (eff_addr == A_PTR1) begin
      rdata_d = ptr1_q;  // RULE5
    end else if (eff_addr == A_BANK) begin
      rdata_d = bank_img;
    end else if (ext_sel) begin
      rdata_d = ext_val;
    end
  end

  // read data is held only in the cycle after a read, zero otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= ZERO_B;
    end else begin
      rdata_q <= rd ? rdata_d : ZERO_B;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr0_q <= RST_PTR;
      ptr1_q <= RST_PTR;
    end else begin
      if (wr_ptr0) begin
        ptr0_q <= wdata;  // RULE5
      end
      if (wr_ptr1) begin
        ptr1_q <= wdata;  // RULE5
      end
    end
  end

  // power-on reset clears the bank; later resets arrive as rst_evt
  // so that a watchdog wake can leave the bank untouched
  // rst_evt beats a same-cycle bank write, so software never undoes a reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank_q <= RST_BANK;
    end else if (rst_evt) begin
      if (!rst_keep_bank) begin
        bank_q <= RST_BANK;  // RULE9
      end
    end else if (wr_bank) begin
      bank_q <= wdata[BANK_BIT];  // RULE8
    end
  end

  assign rdata    = rdata_q;
  assign bank_sel = bank_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence win0_wr_s;
    wr && win0_hit && is_gp(ptr0_q);
  endsequence

  sequence win1_acc_s;
    access && win1_hit && is_gp(ptr1_q);
  endsequence

  sequence nested_rd_s;
    rd && indirect && is_window(eff_addr);
  endsequence

  win0_redirect_a: assert property ( // RULE1
    win0_wr_s |-> ram_we && (ram_idx == IW'(ptr0_q - GP_BASE)))
    else $error("first window write not sent to pointed ram word");

  win0_bank0_a: assert property ( // RULE2
    win0_wr_s |-> !eff_bank)
    else $error("first window reached a bank other than 0");

  win1_bank_a: assert property ( // RULE3
    win1_acc_s |-> eff_bank == bank_q)
    else $error("second window ignored the bank select bit");

  nested_read_a: assert property ( // RULE4
    nested_rd_s |=> rdata == ZERO_B)
    else $error("window read through pointer was not zero");

  nested_write_a: assert property ( // RULE4
    wr && null_hit |-> !ram_we && !ext_req.wr ##1 $stable(ptr0_q) && $stable(ptr1_q))
    else $error("window write through pointer had an effect");

  ptr_store_a: assert property ( // RULE5
    wr && !indirect && addr == A_PTR1 |=> ptr1_q == $past(wdata) ##1 1'b1)
    else $error("pointer did not store written value");

  ptr_read_a: assert property ( // RULE5
    rd && !indirect && addr == A_PTR0 |=> rdata == $past(ptr0_q))
    else $error("pointer read back wrong value");

  direct_bank0_a: assert property ( // RULE6
    access && !indirect && is_gp(addr) |-> !eff_bank)
    else $error("direct access left bank 0");

  unused_zero_a: assert property ( // RULE7
    rd && !indirect && addr < GP_BASE && !is_own(addr) && !is_window(addr) && !ext_hit
      |=> rdata == ZERO_B)
    else $error("unused special location read nonzero");

  bank_bits_a: assert property ( // RULE8
    rd && !indirect && addr == A_BANK |=> rdata == {7'h00, $past(bank_q)})
    else $error("bank select register read wrong");

  bank_reset_a: assert property ( // RULE9
    rst_evt && !rst_keep_bank |=> !bank_q)
    else $error("reset did not return bank to 0");

  bank_keep_a: assert property ( // RULE9
    rst_evt && rst_keep_bank |=> bank_q == $past(bank_q))
    else $error("watchdog sleep reset changed the bank");

  // pointers, bank register and forwarding to other blocks
  sequence bank_wr_s;
    wr && !rst_evt && ((addr == A_BANK && !indirect) || (win0_hit && ptr0_q == A_BANK) ||
      (win1_hit && ptr1_q == A_BANK));
  endsequence

  sequence ext_rd_s;
    rd && !indirect && addr < GP_BASE && !is_own(addr) && !is_window(addr);
  endsequence

  sequence ext_wr_s;
    wr && !indirect && addr < GP_BASE && !is_own(addr) && !is_window(addr);
  endsequence

  ptr0_store_a: assert property ( // RULE5
    wr && !indirect && addr == A_PTR0 |=> ptr0_q == $past(wdata))
    else $error("first pointer did not store written value");

  ptr1_read_a: assert property ( // RULE5
    rd && !indirect && addr == A_PTR1 |=> rdata == $past(ptr1_q))
    else $error("second pointer read back wrong value");

  ptr_hold_a: assert property ( // RULE5
    !wr |=> $stable(ptr0_q) && $stable(ptr1_q))
    else $error("pointer changed without a write");

  own_local_a: assert property ( // RULE5
    access && !indirect && is_own(addr) |-> !ext_req.wr && !ext_req.rd)
    else $error("own register access leaked to other blocks");

  win_chain_a: assert property ( // RULE1
    rd && win0_hit && ptr0_q == A_PTR1 |=> rdata == $past(ptr1_q))
    else $error("first window did not read the pointed register");

  win_ptr_write_a: assert property ( // RULE1
    wr && win1_hit && ptr1_q == A_PTR0 |=> ptr0_q == $past(wdata))
    else $error("second window did not write the pointed register");

  nested_no_fwd_a: assert property ( // RULE4
    nested_rd_s |-> !ext_req.rd)
    else $error("window read through pointer reached another block");

  direct_write_a: assert property ( // RULE6
    wr && !indirect && is_gp(addr) |-> ram_we && !eff_bank && ram_idx == IW'(addr - GP_BASE))
    else $error("direct ram write not sent to bank 0 word");

  ext_write_a: assert property ( // RULE6
    ext_wr_s |-> ext_req.wr && ext_req.addr == addr && ext_req.wdata == wdata)
    else $error("special location write not forwarded");

  ext_forward_a: assert property ( // RULE7
    ext_rd_s |-> ext_req.rd && ext_req.addr == addr)
    else $error("special location read not forwarded");

  ext_answer_a: assert property ( // RULE7
    ext_rd_s ##0 ext_hit |=> rdata == $past(ext_rdata))
    else $error("implemented special location read wrong");

  bank_write_a: assert property ( // RULE8
    bank_wr_s |=> bank_q == $past(wdata[BANK_BIT]))
    else $error("bank select bit did not take written value");

  bank_hold_a: assert property ( // RULE8
    !rst_evt && !wr |=> $stable(bank_q))
    else $error("bank changed without write or reset");

  bank_indirect_a: assert property ( // RULE8
    rd && win1_hit && ptr1_q == A_BANK |=> rdata == {7'h00, $past(bank_q)})
    else $error("bank select register read through window wrong");

endmodule

// ### core/dmi_pkg.sv
// data memory indirect addressing: shared constants and types
// assumes one clock domain; no module of its own
package dmi_pkg;

  localparam int AW = 8;
  localparam int DW = 8;

  // operand address map of the special region
  localparam logic [7:0] A_WIN0  = 8'h00;
  localparam logic [7:0] A_PTR0  = 8'h01;
  localparam logic [7:0] A_WIN1  = 8'h02;
  localparam logic [7:0] A_PTR1  = 8'h03;
  localparam logic [7:0] A_BANK  = 8'h04;

  // general purpose ram starts here, special region lies below
  localparam logic [7:0] GP_BASE = 8'h80;

  // bank select field
  localparam int         BANK_BIT = 0;

  // reset values and fixed answers
  localparam logic [7:0] RST_PTR  = 8'h00;
  localparam logic       RST_BANK = 1'b0;
  localparam logic [7:0] ZERO_B   = 8'h00;

  // general purpose words in each bank, and number of banks
  localparam int RAM_WORDS_DEF = 64;
  localparam int NUM_BANKS     = 2;

  // forwarded access to special registers owned by other blocks
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dmi_sfr_req_t;

endpackage

// ### verif/dmi_ext_model.sv
// far-side special register owner answering forwarded accesses
// assumes dmi_core forwards ext_req combinationally, one access per cycle
`timescale 1ns/10ps
module dmi_ext_model
  import dmi_pkg::*;
#(
  parameter logic [7:0] OWN_ADDR = 8'h20
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire dmi_sfr_req_t ext_req,
  output logic      [7:0]   ext_rdata,
  output logic              ext_hit
);
  logic [7:0] reg_q;

  assign ext_hit   = (ext_req.addr == OWN_ADDR);
  // unowned addresses see inverted data so a missing zero shows up
  assign ext_rdata = ext_hit ? reg_q : ~reg_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) reg_q <= 8'h3c;
    else if (ext_req.wr && ext_hit) reg_q <= ext_req.wdata;
  end
endmodule

// ### verif/testbench.sv
// self-checking bench for the data memory address logic
// assumes dmi_ext_model owns the special register at 20h only
`timescale 1ns/10ps
module testbench
  import dmi_pkg::*;
;
  logic         clk, nrst, wr, rd, rst_evt, rst_keep_bank, bank_sel, ext_hit;
  logic [7:0]   addr, wdata, rdata, ext_rdata;
  dmi_sfr_req_t ext_req;
  int           n_errors = 0;
  int           compares = 0;

  dmi_core #(.RAM_WORDS(64)) dmi_core_inst (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rst_evt(rst_evt),
    .rst_keep_bank(rst_keep_bank), .ext_req(ext_req), .ext_rdata(ext_rdata),
    .ext_hit(ext_hit), .bank_sel(bank_sel));
  dmi_ext_model dmi_ext_model_inst (.clk(clk), .nrst(nrst), .ext_req(ext_req),
    .ext_rdata(ext_rdata), .ext_hit(ext_hit));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr_op(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic t_pointers;
    rd_chk(A_PTR0, RST_PTR);
    wr_op(A_PTR0, 8'ha5);
    wr_op(A_PTR1, 8'h5a);
    rd_chk(A_PTR0, 8'ha5);
    rd_chk(A_PTR1, 8'h5a);
  endtask

  task automatic t_windows;
    wr_op(A_BANK, 8'h01);
    wr_op(A_PTR0, GP_BASE);
    wr_op(A_WIN0, 8'h11);
    wr_op(A_PTR1, GP_BASE);
    wr_op(A_WIN1, 8'h22);
    rd_chk(GP_BASE, 8'h11);
    rd_chk(A_WIN0, 8'h11);
    rd_chk(A_WIN1, 8'h22);
    rd_chk(A_WIN0, 8'h11);
    wr_op(8'h81, 8'h33);
    wr_op(A_PTR1, 8'h81);
    wr_op(A_WIN1, 8'h44);
    rd_chk(8'h81, 8'h33);
    rd_chk(A_WIN1, 8'h44);
    wr_op(A_PTR1, GP_BASE);
    wr_op(A_BANK, 8'h00);
    rd_chk(A_WIN1, 8'h11);
    wr_op(A_PTR1, A_PTR0);
    wr_op(A_WIN1, 8'h85);
    rd_chk(A_PTR0, 8'h85);
  endtask

  task automatic t_null_window;
    wr_op(A_PTR0, A_WIN0);
    wr_op(A_WIN0, 8'h77);
    rd_chk(A_WIN0, ZERO_B);
    wr_op(A_PTR1, A_WIN1);
    wr_op(A_WIN1, 8'h66);
    rd_chk(A_WIN1, ZERO_B);
    rd_chk(A_PTR1, A_WIN1);
  endtask

  task automatic t_unused;
    wr_op(8'h10, 8'h99);
    rd_chk(8'h10, ZERO_B);
    wr_op(8'h20, 8'h4b);
    rd_chk(8'h20, 8'h4b);
    wr_op(A_BANK, 8'hff);
    rd_chk(A_BANK, 8'h01);
  endtask

  task automatic reset_evt(input logic keep, input logic exp);
    @(posedge clk);
    rst_evt       <= 1'b1;
    rst_keep_bank <= keep;
    @(posedge clk);
    rst_evt       <= 1'b0;
    rst_keep_bank <= 1'b0;
    #1 chk({7'h0, bank_sel}, {7'h0, exp});
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    nrst          = 1'b0;
    addr          = 8'h00;
    wdata         = 8'h00;
    wr            = 1'b0;
    rd            = 1'b0;
    rst_evt       = 1'b0;
    rst_keep_bank = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({7'h0, bank_sel}, 8'h00);
    t_pointers();
    t_windows();
    t_null_window();
    t_unused();
    reset_evt(1'b1, 1'b1);
    reset_evt(1'b0, 1'b0);
    stop_test();
  end
endmodule
